// ==== dv/serial_node_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Shifters and line of the remote node
// ****************************************
module serial_node_model
    import uart_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic [1:0] tx_load,
    output logic [1:0] base_tick,
    output logic [1:0] rx_char_valid,
    output logic [15:0] rx_char,
    output logic [1:0] rx_parity_bit,
    output logic [1:0] rx_stop_bit,
    output logic [1:0] tx_idle,
    output logic [1:0] tx_frame_done,
    output logic [1:0] tx_line,
    output logic [1:0] serial_in_pin
);
    logic [1:0] tick_q;
    logic [3:0] busy_q [2];
    logic [1:0] pin_q = 2'b11;
    assign base_tick = {2{tick_q == 2'd0}};
    assign serial_in_pin = pin_q;
    assign tx_idle = {busy_q[1] == 4'd0, busy_q[0] == 4'd0};
    initial begin
        rx_char_valid = 2'b00;
        rx_char = 16'h0000;
        rx_parity_bit = 2'b00;
        rx_stop_bit = 2'b11;
    end
    // Line toggles while busy so a stale level never passes for a real one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tick_q <= 2'd0;
            busy_q <= '{4'd0, 4'd0};
            tx_frame_done <= 2'b00;
            tx_line <= 2'b11;
        end else begin
            tick_q <= tick_q + 2'd1;
            for (int g = 0; g < 2; g++) begin
                busy_q[g] <= tx_load[g] ? (slow ? 4'd12 : 4'd3) : busy_q[g] - 4'(busy_q[g] != 4'd0);
                tx_frame_done[g] <= busy_q[g] == 4'd1;
                tx_line[g] <= busy_q[g] == 4'd0 || tick_q[0];
            end
        end
    end
    task automatic send(input int ch, input logic [7:0] d, input logic pb, input logic sb);
        rx_char[ch*8 +: 8] <= d;
        rx_parity_bit[ch] <= pb;
        rx_stop_bit[ch] <= sb;
        rx_char_valid[ch] <= 1'b1;
        @(posedge core_clk);
        rx_char[ch*8 +: 8] <= ~d;
        rx_parity_bit[ch] <= ~pb;
        rx_stop_bit[ch] <= ~sb;
        rx_char_valid[ch] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/uart_mode_control_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Port checks of the mode control
// ****************************************
module uart_mode_control_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [1:0] base_tick,
    input wire logic [1:0] rx_char_valid,
    input wire logic [1:0] tx_idle,
    input wire logic [1:0] tx_line,
    input wire logic [1:0] serial_in_pin,
    input wire logic [1:0] tx_output_invert,
    input wire logic [1:0] serial_out_pin,
    input wire logic [1:0] rx_line,
    input wire logic [1:0] channel_clk_run,
    input wire logic [1:0] tx_run,
    input wire logic [1:0] rx_run,
    input wire logic [1:0] tx_load,
    input wire logic [15:0] tx_data,
    input wire logic [1:0] char_len8,
    input wire logic [1:0] rx_done_irq,
    input wire logic [1:0] rx_error_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    pin_idle_a: assert property (!channel_clk_run[0] |-> serial_out_pin[0] == !tx_output_invert[0] && rx_line[0])
        else $error("idle pin level wrong");
    pin_pass_a: assert property (channel_clk_run[1] |-> rx_line[1] == serial_in_pin[1]
        && serial_out_pin[1] == (tx_line[1] ^ tx_output_invert[1])) else $error("pin not passed through");
    run_power_a: assert property (((tx_run | rx_run) & ~channel_clk_run) == 2'b00)
        else $error("channel runs while powered off");
    // Enables are resynchronised, so a run output may only rise after a base tick
    run_tick_a: assert property ($rose(tx_run[1]) || $rose(rx_run[1]) |-> $past(base_tick[1]))
        else $error("enable passed without base tick");
    load_cause_a: assert property (tx_load[1] |-> $past(tx_run[1]) && $past(tx_idle[1]))
        else $error("load while transmit disabled");
    len_seven_a: assert property (tx_load[0] && !char_len8[0] |-> !tx_data[7])
        else $error("bit 7 sent in 7-bit mode");
    irq_one_a: assert property ((rx_done_irq & rx_error_irq) == 2'b00)
        else $error("both receive interrupts raised");
    irq_cause_a: assert property (rx_char_valid[1] && rx_run[1] |-> ##[1:2] (rx_done_irq[1] ^ rx_error_irq[1]))
        else $error("no single interrupt for character");
    cover property (tx_load[1] && char_len8[1]);
    cover property (rx_error_irq[0]);
    cover property (rx_done_irq[1]);
endmodule
bind uart_mode_control uart_mode_control_checker u_chk (.*);
`default_nettype wire

// ==== dv/uart_mode_control_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module uart_mode_control_test;
    import uart_mode_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr;
    logic [1:0] tx_output_invert = 2'b00;
    logic [1:0] base_tick, rx_char_valid, rx_parity_bit, rx_stop_bit, tx_idle, tx_frame_done, tx_line;
    logic [1:0] serial_in_pin, serial_out_pin, rx_line, channel_clk_run, tx_run, rx_run, tx_load;
    logic [1:0] tx_parity_en, tx_parity_bit, tx_stop_two, char_len8, rx_done_irq, rx_error_irq;
    logic [15:0] rx_char, tx_data;
    int num_errors = 0, compares = 0, cycles = 0;
    uart_mode_control u_dut (.*);
    serial_node_model u_node (.*);
    always #5 core_clk = ~core_clk;
    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic close_out();
        $display("mismatches %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d, output logic [7:0] r,
                       output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdc(input logic [17:0] a, input logic [7:0] x);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, x);
        chk(e, 1'b0);
    endtask
    function automatic logic [17:0] mode_a(input int ch);
        return {(ch == 0) ? MODE_IDX_CH0 : MODE_IDX_CH1, 2'b00};
    endfunction
    function automatic logic [17:0] aux_a(input int ch, input logic [15:0] ofs);
        return {AUX_BASE_IDX + AUX_CH_STRIDE * 16'(ch) + ofs, 2'b00};
    endfunction
    // Selects 0 transmit run, 1 transmit load, 2 receive run
    task automatic wait_sig(input int sel, input int ch);
        int n = 0;
        while (n < 200 && (sel == 0 ? tx_run[ch] : sel == 1 ? tx_load[ch] : rx_run[ch]) !== 1'b1) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 200) num_errors++;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] r;
        logic e;
        rdc(mode_a(0), 8'h01);
        rdc(mode_a(1), 8'h01);
        chk({serial_out_pin, rx_line, channel_clk_run}, 6'b111100);
        tx_output_invert <= 2'b10;
        @(posedge core_clk);
        chk(serial_out_pin, 2'b01);
        tx_output_invert <= 2'b00;
        wr(mode_a(1), 8'h1f);
        rdc(mode_a(1), 8'h1f);
        wr(mode_a(1), 8'h01);
        apb(1'b0, 18'h00004, 8'h00, r, e);
        chk(e, 1'b1);
        wr(mode_a(0), 8'h85);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rdc(mode_a(0), 8'h01);
        chk(channel_clk_run, 2'b00);
    endtask
    task automatic t_power(input int ch);
        wr(mode_a(ch), 8'h81);
        chk(channel_clk_run[ch], 1'b1);
        wr(aux_a(ch, EXT_OFS), 8'hc0);
        rdc(aux_a(ch, EXT_OFS), 8'hc0);
        wr(mode_a(ch), 8'ha1);
        wait_sig(2, ch);
        u_node.send(ch, 8'h5a, 1'b0, 1'b1);
        wr(mode_a(ch), 8'h81);
        repeat (8) @(posedge core_clk);
        u_node.pin_q[ch] <= 1'b0;
        @(posedge core_clk);
        chk(rx_line[ch], 1'b0);
        wr(mode_a(ch), 8'h01);
        chk({channel_clk_run[ch], rx_line[ch]}, 2'b01);
        rdc(aux_a(ch, RXB_OFS), 8'hff);
        rdc(aux_a(ch, EXT_OFS), 8'h00);
        u_node.pin_q[ch] <= 1'b1;
    endtask
    task automatic t_tx(input int ch);
        logic [7:0] d, m;
        for (int k = 0; k < 8; k++) begin
            m = {3'b100, k[2:1], k[0], k[1], 1'b1};
            d = (8'hc5 ^ 8'(k)) & (k[0] ? 8'hff : 8'h7f);
            wr(mode_a(ch), m);
            wr(mode_a(ch), m | 8'h40);
            wait_sig(0, ch);
            chk({tx_stop_two[ch], char_len8[ch], tx_parity_en[ch]}, {k[1], k[0], k[2:1] != 2'd0});
            wr(aux_a(ch, TXB_OFS), d);
            wait_sig(1, ch);
            chk(tx_data[ch*8 +: 8], d);
            chk(tx_parity_bit[ch] & tx_parity_en[ch], k[2:1] == 2 ? ~^d : k[2:1] == 3 ? ^d : 1'b0);
            rdc(aux_a(ch, TXST_OFS), 8'h01);
            rdc(aux_a(ch, TXB_OFS), d);
            wr(mode_a(ch), m);
            repeat (8) @(posedge core_clk);
            rdc(aux_a(ch, TXST_OFS), 8'h00);
        end
    endtask
    task automatic rx_case(input int ch, input logic [1:0] par, input logic cl, input logic rt, input logic sl,
                           input logic [7:0] d, input logic pb, input logic sb, input logic [2:0] ee, input logic ed);
        logic dn, er;
        wr(mode_a(ch), {3'b100, par, cl, sl, rt});
        wr(mode_a(ch), {3'b101, par, cl, sl, rt});
        wait_sig(2, ch);
        u_node.send(ch, d, pb, sb);
        dn = 1'b0;
        er = 1'b0;
        repeat (3) begin
            @(posedge core_clk);
            dn |= rx_done_irq[ch];
            er |= rx_error_irq[ch];
        end
        chk({dn, er}, {ed, ~ed});
        rdc(aux_a(ch, ERR_OFS), {5'b00000, ee});
        rdc(aux_a(ch, RXB_OFS), d & (cl ? 8'hff : 8'h7f));
        wr(mode_a(ch), {3'b100, par, cl, sl, rt});
        repeat (8) @(posedge core_clk);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        for (int ch = 0; ch < 2; ch++) begin
            t_power(ch);
            slow <= 1'b1;
            t_tx(ch);
            slow <= 1'b0;
            rx_case(ch, 2'd2, 1'b0, 1'b0, 1'b0, 8'h03, 1'b0, 1'b1, 3'b100, 1'b0);
            rx_case(ch, 2'd2, 1'b0, 1'b1, 1'b0, 8'h83, 1'b1, 1'b1, 3'b000, 1'b1);
            rx_case(ch, 2'd3, 1'b1, 1'b1, 1'b0, 8'h03, 1'b1, 1'b1, 3'b100, 1'b1);
            rx_case(ch, 2'd1, 1'b1, 1'b0, 1'b0, 8'h03, 1'b1, 1'b1, 3'b000, 1'b1);
            rx_case(ch, 2'd0, 1'b1, 1'b0, 1'b1, 8'h03, 1'b1, 1'b0, 3'b010, 1'b0);
        end
        close_out();
    end
endmodule
`default_nettype wire

// ==== src/mode_chan_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface mode_chan_if;
    logic wr_mode;
    logic wr_txb;
    logic wr_ext;
    logic rd_err;
    logic rd_rxb;
    logic [7:0] wdata;
    logic [7:0] mode;
    logic [2:0] err;
    logic [1:0] txstate;
    logic [7:0] rxb;
    logic [7:0] txb;
    logic [1:0] brk;
    modport ctrl (output wr_mode, wr_txb, wr_ext, rd_err, rd_rxb, wdata,
                  input mode, err, txstate, rxb, txb, brk);
    modport chan (input wr_mode, wr_txb, wr_ext, rd_err, rd_rxb, wdata,
                  output mode, err, txstate, rxb, txb, brk);
endinterface
`default_nettype wire

// ==== src/uart_mode_channel.sv ====
`timescale 1ns/10ps
`default_nettype none
module uart_mode_channel
    import uart_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    mode_chan_if.chan bus,
    input wire logic base_tick,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_bit,
    input wire logic rx_stop_bit,
    input wire logic tx_idle,
    input wire logic tx_frame_done,
    input wire logic tx_line,
    input wire logic serial_in_pin,
    input wire logic tx_output_invert,
    output logic serial_out_pin,
    output logic rx_line,
    output logic channel_clk_run,
    output logic tx_run,
    output logic rx_run,
    output logic tx_load,
    output logic [7:0] tx_data,
    output logic tx_parity_en,
    output logic tx_parity_bit,
    output logic tx_stop_two,
    output logic char_len8,
    output logic rx_done_irq,
    output logic rx_error_irq
);
    typedef struct packed {
        logic [7:0] mode;
        logic txen_s;
        logic rxen_s;
        logic [2:0] err;
        logic [7:0] rxb;
        logic rxfull;
        logic [7:0] txb;
        logic txbf;
        logic txsf;
        logic [1:0] brk;
        logic load;
        logic [7:0] tdata;
        logic tpar;
        logic done_irq;
        logic err_irq;
    } chan_state_type;

    chan_state_type st_q, st_d;
    logic power;
    parity_mode_type pmode;
    logic [7:0] rx_masked;
    logic [7:0] tx_masked;
    logic pe_new;
    logic fe_new;
    logic ove_new;
    logic any_err;

    assign power = st_q.mode[POWER_BIT];
    assign pmode = parity_mode_type'(st_q.mode[PAR_HI_BIT:PAR_LO_BIT]);

    // **************************************************
    // Pin gating
    // **************************************************
    // Combinational so the pins go idle in the same cycle power drops
    assign serial_out_pin = (power ? tx_line : 1'b1) ^ tx_output_invert;
    assign rx_line = power ? serial_in_pin : 1'b1;
    assign channel_clk_run = power;
    // A low line at enable starts reception at once; the shifter sees rx_line
    assign tx_run = power & st_q.txen_s;
    assign rx_run = power & st_q.rxen_s;

    assign char_len8 = st_q.mode[CLEN_BIT];
    assign tx_stop_two = st_q.mode[STOP_BIT];
    assign tx_parity_en = (pmode != PAR_NONE);
    assign tx_load = st_q.load;
    assign tx_data = st_q.tdata;
    assign tx_parity_bit = st_q.tpar;
    assign rx_done_irq = st_q.done_irq;
    assign rx_error_irq = st_q.err_irq;

    assign bus.mode = st_q.mode;
    assign bus.err = st_q.err;
    assign bus.txstate = {st_q.txbf, st_q.txsf};
    assign bus.rxb = st_q.rxb;
    assign bus.txb = st_q.txb;
    assign bus.brk = st_q.brk;

    // **************************************************
    // Receive checks
    // **************************************************
    assign rx_masked = st_q.mode[CLEN_BIT] ? rx_char : {1'b0, rx_char[6:0]};
    assign tx_masked = st_q.mode[CLEN_BIT] ? st_q.txb : {1'b0, st_q.txb[6:0]};
    always_comb begin
        pe_new = 1'b0;
        case (pmode)
            PAR_ODD: pe_new = ~(^{rx_masked, rx_parity_bit});
            PAR_EVEN: pe_new = ^{rx_masked, rx_parity_bit};
            default: pe_new = 1'b0;
        endcase
    end
    // Only the first stop bit is ever looked at
    assign fe_new = ~rx_stop_bit;
    // A read in the same cycle frees the buffer, so the new character is kept
    assign ove_new = st_q.rxfull & ~bus.rd_rxb;
    assign any_err = pe_new | fe_new | ove_new;

    // **************************************************
    // State update
    // **************************************************
    always_comb begin
        st_d = st_q;
        st_d.load = 1'b0;
        st_d.done_irq = 1'b0;
        st_d.err_irq = 1'b0;
        if (bus.wr_mode) begin
            st_d.mode = bus.wdata;
        end
        if (bus.wr_ext) begin
            st_d.brk = {bus.wdata[BRK_RX_BIT], bus.wdata[BRK_TX_BIT]};
        end
        // Enables follow the base clock, so a re-enable inside two ticks may miss the reset
        if (base_tick) begin
            st_d.txen_s = st_q.mode[TXE_BIT];
            st_d.rxen_s = st_q.mode[RXE_BIT];
        end
        if (bus.rd_err) begin
            st_d.err = 3'h0;
        end
        if (bus.rd_rxb) begin
            st_d.rxfull = 1'b0;
        end
        // Writes before the enable has passed the base clock are dropped
        if (bus.wr_txb && tx_run && !st_q.txbf) begin
            st_d.txb = bus.wdata;
            st_d.txbf = 1'b1;
        end
        if (tx_frame_done) begin
            st_d.txsf = 1'b0;
        end
        if (tx_run && st_q.txbf && tx_idle && !st_q.load) begin
            st_d.load = 1'b1;
            st_d.tdata = tx_masked;
            st_d.txbf = 1'b0;
            st_d.txsf = 1'b1;
            case (pmode)
                PAR_ODD: st_d.tpar = ~(^tx_masked);
                PAR_EVEN: st_d.tpar = ^tx_masked;
                default: st_d.tpar = 1'b0;
            endcase
        end
        // Set after clear, so an event in the read cycle is kept
        if (rx_run && rx_char_valid) begin
            st_d.err = st_d.err | {pe_new, fe_new, ove_new};
            if (!ove_new) begin
                st_d.rxb = rx_masked;
                st_d.rxfull = 1'b1;
            end
            st_d.done_irq = ~any_err | st_q.mode[ROUTE_BIT];
            st_d.err_irq = any_err & ~st_q.mode[ROUTE_BIT];
        end
        if (!tx_run) begin
            st_d.txbf = 1'b0;
            st_d.txsf = 1'b0;
            st_d.load = 1'b0;
        end
        if (!rx_run) begin
            st_d.err = 3'h0;
            st_d.done_irq = 1'b0;
            st_d.err_irq = 1'b0;
        end
        if (!power) begin
            st_d.txen_s = 1'b0;
            st_d.rxen_s = 1'b0;
            st_d.err = 3'h0;
            st_d.rxb = RXB_RESET;
            st_d.rxfull = 1'b0;
            st_d.brk = 2'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{mode: MODE_RESET, rxb: RXB_RESET, txb: TXB_RESET, default: '0};
        end else begin
            st_q <= st_d;
        end
    end
endmodule
`default_nettype wire

// ==== src/uart_mode_control.sv ====
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module uart_mode_control
    import uart_mode_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] base_tick,
    input wire logic [1:0] rx_char_valid,
    input wire logic [15:0] rx_char,
    input wire logic [1:0] rx_parity_bit,
    input wire logic [1:0] rx_stop_bit,
    input wire logic [1:0] tx_idle,
    input wire logic [1:0] tx_frame_done,
    input wire logic [1:0] tx_line,
    input wire logic [1:0] serial_in_pin,
    input wire logic [1:0] tx_output_invert,
    output logic [1:0] serial_out_pin,
    output logic [1:0] rx_line,
    output logic [1:0] channel_clk_run,
    output logic [1:0] tx_run,
    output logic [1:0] rx_run,
    output logic [1:0] tx_load,
    output logic [15:0] tx_data,
    output logic [1:0] tx_parity_en,
    output logic [1:0] tx_parity_bit,
    output logic [1:0] tx_stop_two,
    output logic [1:0] char_len8,
    output logic [1:0] rx_done_irq,
    output logic [1:0] rx_error_irq
);
    typedef struct packed {
        logic done;
        logic hit;
        logic [31:0] rdata;
    } apb_state_type;

    apb_state_type st_q, st_d;
    logic [15:0] idx;
    logic [15:0] aux_ofs;
    logic [7:0] mode_v [NUM_CH];
    logic [2:0] err_v [NUM_CH];
    logic [1:0] txst_v [NUM_CH];
    logic [7:0] rxb_v [NUM_CH];
    logic [7:0] txb_v [NUM_CH];
    logic [1:0] brk_v [NUM_CH];
    logic [NUM_CH-1:0] sel_mode, sel_err, sel_txst, sel_rxb, sel_txb, sel_ext;
    logic [31:0] rd_mux;
    logic any_hit;
    logic commit;

    assign idx = paddr[17:2];
    assign commit = st_q.done & psel & penable;

    // **************************************************
    // Address decode
    // **************************************************
    always_comb begin
        sel_mode = '0;
        sel_err = '0;
        sel_txst = '0;
        sel_rxb = '0;
        sel_txb = '0;
        sel_ext = '0;
        aux_ofs = 16'h0000;
        for (int i = 0; i < NUM_CH; i++) begin
            aux_ofs = AUX_BASE_IDX + AUX_CH_STRIDE * 16'(i);
            if (idx == ((i == 0) ? MODE_IDX_CH0 : MODE_IDX_CH1)) begin
                sel_mode[i] = 1'b1;
            end else if (idx == aux_ofs + ERR_OFS) begin
                sel_err[i] = 1'b1;
            end else if (idx == aux_ofs + TXST_OFS) begin
                sel_txst[i] = 1'b1;
            end else if (idx == aux_ofs + RXB_OFS) begin
                sel_rxb[i] = 1'b1;
            end else if (idx == aux_ofs + TXB_OFS) begin
                sel_txb[i] = 1'b1;
            end else if (idx == aux_ofs + EXT_OFS) begin
                sel_ext[i] = 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        any_hit = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (sel_mode[i]) begin
                rd_mux = {24'h00_0000, mode_v[i]};
                any_hit = 1'b1;
            end else if (sel_err[i]) begin
                rd_mux = {29'h0000_0000, err_v[i]};
                any_hit = 1'b1;
            end else if (sel_txst[i]) begin
                rd_mux = {30'h0000_0000, txst_v[i]};
                any_hit = 1'b1;
            end else if (sel_rxb[i]) begin
                rd_mux = {24'h00_0000, rxb_v[i]};
                any_hit = 1'b1;
            end else if (sel_txb[i]) begin
                rd_mux = {24'h00_0000, txb_v[i]};
                any_hit = 1'b1;
            end else if (sel_ext[i]) begin
                rd_mux = {24'h00_0000, brk_v[i], 6'h00};
                any_hit = 1'b1;
            end
        end
    end

    // **************************************************
    // Bus slave
    // **************************************************
    // One wait state keeps read data registered
    always_comb begin
        st_d = st_q;
        if (st_q.done) begin
            st_d.done = 1'b0;
        end else if (psel && penable) begin
            st_d.done = 1'b1;
            st_d.hit = any_hit;
            st_d.rdata = pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready = st_q.done;
    assign prdata = st_q.rdata;
    // Unmapped addresses answer with an error and read as zero
    assign pslverr = st_q.done & ~st_q.hit;

    // **************************************************
    // Channels
    // **************************************************
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
            mode_chan_if bus ();
            assign bus.wr_mode = commit & pwrite & sel_mode[g];
            assign bus.wr_txb = commit & pwrite & sel_txb[g];
            assign bus.wr_ext = commit & pwrite & sel_ext[g];
            assign bus.rd_err = commit & ~pwrite & sel_err[g];
            assign bus.rd_rxb = commit & ~pwrite & sel_rxb[g];
            assign bus.wdata = pwdata[7:0];
            assign mode_v[g] = bus.mode;
            assign err_v[g] = bus.err;
            assign txst_v[g] = bus.txstate;
            assign rxb_v[g] = bus.rxb;
            assign txb_v[g] = bus.txb;
            assign brk_v[g] = bus.brk;
            uart_mode_channel u_chan (
                .core_clk(core_clk),
                .rstn(rstn),
                .bus(bus),
                .base_tick(base_tick[g]),
                .rx_char_valid(rx_char_valid[g]),
                .rx_char(rx_char[8*g +: 8]),
                .rx_parity_bit(rx_parity_bit[g]),
                .rx_stop_bit(rx_stop_bit[g]),
                .tx_idle(tx_idle[g]),
                .tx_frame_done(tx_frame_done[g]),
                .tx_line(tx_line[g]),
                .serial_in_pin(serial_in_pin[g]),
                .tx_output_invert(tx_output_invert[g]),
                .serial_out_pin(serial_out_pin[g]),
                .rx_line(rx_line[g]),
                .channel_clk_run(channel_clk_run[g]),
                .tx_run(tx_run[g]),
                .rx_run(rx_run[g]),
                .tx_load(tx_load[g]),
                .tx_data(tx_data[8*g +: 8]),
                .tx_parity_en(tx_parity_en[g]),
                .tx_parity_bit(tx_parity_bit[g]),
                .tx_stop_two(tx_stop_two[g]),
                .char_len8(char_len8[g]),
                .rx_done_irq(rx_done_irq[g]),
                .rx_error_irq(rx_error_irq[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ==== src/uart_mode_pkg.sv ====
// Functional notes
// - Power bit low stops the channel clock and resets the channel; high runs it.
// - Power off also clears error status, transmit status, break bits and receive buffer.
// - Power off drives the serial output idle (high, low when tx_output_invert is set) and reads the input as high.
// - Transmit enable low disables and synchronously resets the transmit circuit.
// - Receive enable low disables and synchronously resets the receive circuit.
// - Parity field: 00 none, 01 zero bit, 10 odd, 11 even on both directions.
// - Zero parity mode never checks parity, so it never sets the parity error bit.
// - Character length bit selects 7 data bits at 0 and 8 at 1.
// - Stop select bit gives one transmitted stop bit at 0, two at 1.
// - Receiver always checks exactly one stop bit.
// - Error routing 0 raises only the error interrupt, 1 only the completion interrupt.
// - Enabling reception on a low input starts reception at once.
// - Enables are synchronised to the base clock; wait two base clocks to re-enable.
// - Mode register: 8 bits, reset 01, power/tx/rx/parity[1:0]/length/stop/route.
// - Parity error set at reception end when odd or even parity mismatches.
`default_nettype none
package uart_mode_pkg;
    localparam int NUM_CH = 2;
    // Mode register fields
    localparam int POWER_BIT = 7;
    localparam int TXE_BIT = 6;
    localparam int RXE_BIT = 5;
    localparam int PAR_HI_BIT = 4;
    localparam int PAR_LO_BIT = 3;
    localparam int CLEN_BIT = 2;
    localparam int STOP_BIT = 1;
    localparam int ROUTE_BIT = 0;
    // Error status fields
    localparam int PE_BIT = 2;
    localparam int FE_BIT = 1;
    localparam int OVE_BIT = 0;
    // Extended control break bits
    localparam int BRK_RX_BIT = 7;
    localparam int BRK_TX_BIT = 6;
    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] RXB_RESET = 8'hff;
    localparam logic [7:0] TXB_RESET = 8'hff;
    // Word indices; byte address is four times the index
    localparam logic [15:0] MODE_IDX_CH0 = 16'hff2e;
    localparam logic [15:0] MODE_IDX_CH1 = 16'hff2f;
    localparam logic [15:0] AUX_BASE_IDX = 16'h0100;
    localparam logic [15:0] AUX_CH_STRIDE = 16'h0010;
    localparam logic [15:0] ERR_OFS = 16'h0000;
    localparam logic [15:0] TXST_OFS = 16'h0001;
    localparam logic [15:0] RXB_OFS = 16'h0002;
    localparam logic [15:0] TXB_OFS = 16'h0003;
    localparam logic [15:0] EXT_OFS = 16'h0004;
    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_ZERO,
        PAR_ODD,
        PAR_EVEN
    } parity_mode_type;
endpackage
`default_nettype wire
